// ### nvac_pkg.sv
// Package: register map, fields, reset values and types of the nonvolatile access controller
package nvac_pkg;

  // ****************************************************************
  // Widths and limits
  // ****************************************************************
  localparam int unsigned NVAC_ADDR_W     = 21;
  localparam int unsigned NVAC_DATA_W     = 8;
  localparam int unsigned NVAC_BUS_ADDR_W = 8;
  // First program address past the implemented flash (plain default)
  localparam logic [20:0] NVAC_FLASH_LIMIT = 21'h002000;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] NVAC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] NVAC_OFS_UNLOCK  = 8'h04;
  localparam logic [7:0] NVAC_OFS_ADDRESS = 8'h08;
  localparam logic [7:0] NVAC_OFS_DATA    = 8'h0c;
  localparam logic [7:0] NVAC_OFS_FLAGS   = 8'h10;
  localparam logic [7:0] NVAC_OFS_STATUS  = 8'h14;
  localparam logic [7:0] NVAC_OFS_TPTR    = 8'h18;
  localparam logic [7:0] NVAC_OFS_TLATCH  = 8'h1c;

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int unsigned NVAC_CTL_RD    = 0;
  localparam int unsigned NVAC_CTL_WR    = 1;
  localparam int unsigned NVAC_CTL_WRITE_PERMIT  = 2;
  localparam int unsigned NVAC_CTL_WRITE_ABORT_FLAG = 3;
  localparam int unsigned NVAC_CTL_ERASE = 4;
  localparam int unsigned NVAC_CTL_CONFIG_SPACE_SELECT  = 6;
  localparam int unsigned NVAC_CTL_PGD   = 7;
  localparam int unsigned NVAC_FLG_WCF   = 0;

  // ****************************************************************
  // Unlock keys and reset values
  // ****************************************************************
  localparam logic [7:0]  NVAC_KEY_FIRST  = 8'h55;
  localparam logic [7:0]  NVAC_KEY_SECOND = 8'haa;
  localparam logic [20:0] NVAC_ADDR_RST   = 21'h000000;
  localparam logic [7:0]  NVAC_DATA_RST   = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    NVAC_SP_EEPROM = 2'h0,
    NVAC_SP_FLASH  = 2'h1,
    NVAC_SP_CONFIG = 2'h2
  } nvac_space_e;

  typedef enum logic [1:0] {
    NVAC_OP_READ  = 2'h0,
    NVAC_OP_WRITE = 2'h1,
    NVAC_OP_ERASE = 2'h2
  } nvac_op_e;

  typedef struct packed {
    logic        req;
    nvac_op_e    op;
    nvac_space_e space;
    logic [20:0] addr;
    logic [7:0]  wdata;
  } nvac_mem_req_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } nvac_mem_rsp_s;

endpackage

// ### nvac_unlock.sv
// Unlock sequence tracker: two keys written back to back arm one control write
`timescale 1ns/1ns
module nvac_unlock
  import nvac_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_stb,
  input  wire logic       unlock_sel,
  input  wire logic [7:0] wdata,
  output logic            armed
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    NVAC_UL_IDLE  = 2'b00,
    NVAC_UL_FIRST = 2'b01,
    NVAC_UL_ARMED = 2'b11
  } nvac_ul_e;

  typedef struct packed {
    nvac_ul_e st;
  } nvac_ul_s;

  nvac_ul_s s_q;
  nvac_ul_s s_d;

  // Any lane-0 bus write other than the expected key breaks the sequence
  always_comb begin
    s_d = s_q;
    if (wr_stb) begin
      if (unlock_sel && wdata == NVAC_KEY_FIRST) begin
        s_d.st = NVAC_UL_FIRST;
      end else if (unlock_sel && wdata == NVAC_KEY_SECOND && s_q.st == NVAC_UL_FIRST) begin
        s_d.st = NVAC_UL_ARMED;
      end else begin
        s_d.st = NVAC_UL_IDLE;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: NVAC_UL_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  assign armed = (s_q.st == NVAC_UL_ARMED);

endmodule

// ### nvac_top.sv
// Nonvolatile access controller: control registers, unlock, sequencing and abort record
`timescale 1ns/1ns

module nvac_top
  import nvac_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  input  wire logic          power_on_nrst,
  input  wire logic [7:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  output nvac_mem_req_s      mem_req,
  input  wire nvac_mem_rsp_s mem_rsp,
  output logic               busy
);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    NVAC_ST_IDLE = 2'b00,
    NVAC_ST_RD   = 2'b01,
    NVAC_ST_WR   = 2'b11,
    NVAC_ST_TBL  = 2'b10
  } nvac_state_e;

  typedef struct packed {
    nvac_state_e   st;
    logic          pgd;
    logic          config_space_select;
    logic          erase;
    logic          write_permit;
    logic          wr;
    logic          rd;
    logic          wcf;
    logic          live;
    logic [20:0]   addr;
    logic [7:0]    data;
    logic [20:0]   tptr;
    logic [7:0]    tlat;
    logic          ack;
    logic [31:0]   rdata;
    nvac_mem_req_s mem;
  } nvac_main_s;

  // Survives device resets; only power-on clears it
  typedef struct packed {
    logic wip;
    logic write_abort_flag;
  } nvac_keep_s;

  // ****************************************************************
  // Reset synchronisers
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic [1:0] por_sync_q;
  logic       rst_n;
  logic       por_n;

  // Assert at once, release two edges later so no flop sees a runt release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Same treatment for the power-on reset
  always_ff @(posedge ref_clk or negedge power_on_nrst) begin
    if (!power_on_nrst) begin
      por_sync_q <= 2'b00;
    end else begin
      por_sync_q <= {por_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];
  assign por_n = por_sync_q[1];

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic nvac_space_e space_of(input logic config_space_select, input logic pgd);
    if (config_space_select) begin
      space_of = NVAC_SP_CONFIG;
    end else if (pgd) begin
      space_of = NVAC_SP_FLASH;
    end else begin
      space_of = NVAC_SP_EEPROM;
    end
  endfunction

  function automatic logic beyond_flash(input nvac_space_e sp, input logic [20:0] a);
    beyond_flash = (sp == NVAC_SP_FLASH) && (a >= NVAC_FLASH_LIMIT);
  endfunction

  // Byte-lane merge of a 21-bit pointer; lane 0 always lands with the write
  function automatic logic [20:0] merge_ptr(input logic [20:0] old_v, input logic [3:0] be,
                                            input logic [31:0] wd);
    merge_ptr = {be[2] ? wd[20:16] : old_v[20:16],
                 be[1] ? wd[15:8] : old_v[15:8],
                 wd[7:0]};
  endfunction

  // Control register as software sees it; bit 5 is unused and reads zero
  function automatic logic [7:0] ctl_view(input nvac_main_s m, input logic write_abort_flag);
    ctl_view = {m.pgd, m.config_space_select, 1'b0, m.erase, write_abort_flag, m.write_permit, m.wr, m.rd};
  endfunction

  // ****************************************************************
  // State and bus strobes
  // ****************************************************************
  nvac_main_s m_q;
  nvac_main_s m_d;
  nvac_keep_s k_q;
  nvac_keep_s k_d;
  logic       req;
  logic       wr_stb;
  logic       armed;
  logic       wr_lo;
  logic [7:0] wbyte;

  // Bus accesses take effect at the edge where waitrequest is low
  assign req     = avs_read | avs_write;
  assign wr_stb  = avs_write & m_q.ack;
  assign wr_lo   = wr_stb & avs_byteenable[0];  // Lane 0 carries every 8-bit field
  assign wbyte   = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

  nvac_unlock nvac_unlock_i (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .wr_stb     (wr_lo),
    .unlock_sel (avs_address == NVAC_OFS_UNLOCK),
    .wdata      (avs_writedata[7:0]),
    .armed      (armed)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Order matters: completion first, then software writes, so software writes win; the done flag set is applied last
  always_comb begin
    nvac_space_e sp;
    logic        wcf_set;
    logic        wr_go;
    logic        rd_go;
    logic [20:0] tptr_new;
    sp      = space_of(m_q.config_space_select, m_q.pgd);
    wcf_set = 1'b0;
    // Launch needs idle, permit stored before this write and freshly armed keys
    wr_go    = (m_q.st == NVAC_ST_IDLE) && wbyte[NVAC_CTL_WR]
               && m_q.write_permit && armed;
    // Program space is read by table fetches only, never by the read trigger
    rd_go    = (m_q.st == NVAC_ST_IDLE) && wbyte[NVAC_CTL_RD]
               && !wbyte[NVAC_CTL_PGD];
    tptr_new = merge_ptr(m_q.tptr, avs_byteenable, avs_writedata);
    m_d     = m_q;
    k_d     = k_q;
    m_d.live = 1'b1;
    m_d.ack  = req & ~m_q.ack;

    // A reset that caught a write in flight leaves wip behind
    if (!m_q.live && k_q.wip) begin
      k_d.write_abort_flag = 1'b1;
      k_d.wip   = 1'b0;
    end

    // Operation completion
    case (m_q.st)
      NVAC_ST_RD: begin
        if (mem_rsp.ack) begin
          m_d.data    = mem_rsp.rdata;
          m_d.rd      = 1'b0;
          m_d.mem.req = 1'b0;
          m_d.st      = NVAC_ST_IDLE;
        end
      end
      NVAC_ST_WR: begin
        if (mem_rsp.ack || !m_q.mem.req) begin
          m_d.wr      = 1'b0;
          m_d.mem.req = 1'b0;
          m_d.st      = NVAC_ST_IDLE;
          wcf_set     = 1'b1;
          k_d.wip     = 1'b0;
        end
      end
      NVAC_ST_TBL: begin
        if (mem_rsp.ack) begin
          m_d.tlat    = mem_rsp.rdata;
          m_d.mem.req = 1'b0;
          m_d.st      = NVAC_ST_IDLE;
        end
      end
      NVAC_ST_IDLE: begin
        m_d.mem.req = 1'b0;
      end
      default: begin
        m_d.st      = NVAC_ST_IDLE;
        m_d.mem.req = 1'b0;
      end
    endcase

    // Software writes
    if (wr_lo) begin
      case (avs_address)
        NVAC_OFS_CONTROL: begin
          // Selects are frozen while busy so an operation keeps its target
          if (m_q.st == NVAC_ST_IDLE) begin
            m_d.pgd   = wbyte[NVAC_CTL_PGD];
            m_d.config_space_select  = wbyte[NVAC_CTL_CONFIG_SPACE_SELECT];
            m_d.erase = wbyte[NVAC_CTL_ERASE];
          end
          m_d.write_permit = wbyte[NVAC_CTL_WRITE_PERMIT];
          if (!wbyte[NVAC_CTL_WRITE_ABORT_FLAG]) begin
            k_d.write_abort_flag = k_d.write_abort_flag & ~k_q.write_abort_flag;
          end
          if (wr_go) begin
            sp = space_of(wbyte[NVAC_CTL_CONFIG_SPACE_SELECT], wbyte[NVAC_CTL_PGD]);
            m_d.wr        = 1'b1;
            m_d.st        = NVAC_ST_WR;
            k_d.wip       = 1'b1;
            m_d.mem.space = sp;
            m_d.mem.addr  = m_q.addr;
            m_d.mem.wdata = m_q.data;
            m_d.mem.op    = wbyte[NVAC_CTL_ERASE] ? NVAC_OP_ERASE : NVAC_OP_WRITE;
            // Past the implemented flash nothing is there to program
            m_d.mem.req   = ~beyond_flash(sp, m_q.addr);
          end else if (rd_go) begin
            sp = space_of(wbyte[NVAC_CTL_CONFIG_SPACE_SELECT], 1'b0);
            m_d.rd        = 1'b1;
            m_d.st        = NVAC_ST_RD;
            m_d.mem.req   = 1'b1;
            m_d.mem.op    = NVAC_OP_READ;
            m_d.mem.space = sp;
            m_d.mem.addr  = m_q.addr;
          end
        end
        NVAC_OFS_ADDRESS: begin
          m_d.addr = merge_ptr(m_q.addr, avs_byteenable, avs_writedata);
        end
        NVAC_OFS_DATA: begin
          m_d.data = avs_writedata[7:0];
        end
        NVAC_OFS_FLAGS: begin
          // Write one to clear
          if (wbyte[NVAC_FLG_WCF]) begin
            m_d.wcf = 1'b0;
          end
        end
        NVAC_OFS_TPTR: begin
          m_d.tptr = tptr_new;
          // A fetch beyond flash reads as zero, an all-zero no-op word
          if (beyond_flash(NVAC_SP_FLASH, tptr_new)) begin
            m_d.tlat = 8'h00;
          end else if (m_q.st == NVAC_ST_IDLE) begin
            m_d.st        = NVAC_ST_TBL;
            m_d.mem.req   = 1'b1;
            m_d.mem.op    = NVAC_OP_READ;
            m_d.mem.space = NVAC_SP_FLASH;
            m_d.mem.addr  = tptr_new;
          end
        end
        default: begin
          m_d.data = m_d.data;  // Unmapped or read-only: ignored
        end
      endcase
    end

    // Hardware set beats a same-cycle software clear
    if (wcf_set) begin
      m_d.wcf = 1'b1;
    end

    // Read data is captured in the waiting cycle and stands at the answer edge
    if (avs_read && !m_q.ack) begin
      case (avs_address)
        NVAC_OFS_CONTROL: m_d.rdata = {24'h000000, ctl_view(m_q, k_q.write_abort_flag)};
        NVAC_OFS_UNLOCK:  m_d.rdata = 32'h00000000;
        NVAC_OFS_ADDRESS: m_d.rdata = {11'h000, m_q.addr};
        NVAC_OFS_DATA:    m_d.rdata = {24'h000000, m_q.data};
        NVAC_OFS_FLAGS:   m_d.rdata = {31'h00000000, m_q.wcf};
        NVAC_OFS_STATUS:  m_d.rdata = {28'h0000000, k_q.wip, armed, m_q.st};
        NVAC_OFS_TPTR:    m_d.rdata = {11'h000, m_q.tptr};
        NVAC_OFS_TLATCH:  m_d.rdata = {24'h000000, m_q.tlat};
        default:          m_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Device reset clears every control bit except the abort flag, and the data and address holders
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '{st: NVAC_ST_IDLE, addr: NVAC_ADDR_RST, data: NVAC_DATA_RST,
               mem: '{req: 1'b0, op: NVAC_OP_READ, space: NVAC_SP_EEPROM,
                      addr: NVAC_ADDR_RST, wdata: NVAC_DATA_RST},
               default: '0};
    end else begin
      m_q <= m_d;
    end
  end

  // Abort record lives on the power-on reset so a device reset cannot erase it
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      k_q <= '{wip: 1'b0, write_abort_flag: 1'b0};
    end else begin
      k_q <= k_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest = ~m_q.ack;
  assign avs_readdata    = m_q.rdata;
  assign mem_req         = m_q.mem;
  assign busy            = (m_q.st != NVAC_ST_IDLE);

endmodule

// ### nvac_monitor.sv
// Port checker for the nonvolatile access controller, bound to its top
`timescale 1ns/1ns
module nvac_monitor
  import nvac_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          nrst,
  input wire logic [7:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_writedata,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire nvac_mem_req_s mem_req,
  input wire nvac_mem_rsp_s mem_rsp,
  input wire logic          busy
);
  // ********
  // Sequences
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Trigger write on the control register, taken at this edge
  sequence ctl_go;
    avs_write && !avs_waitrequest && avs_address == NVAC_OFS_CONTROL &&
      avs_writedata[NVAC_CTL_WR];
  endsequence
  // Accepted launch: the memory request rises one edge later
  sequence launch;
    ctl_go ##1 $rose(mem_req.req);
  endsequence

  // ********
  // Assertions
  // ********
  // Fixed latency keeps software timing predictable
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus answer not after one wait cycle");
  req_hold_a: assert property (mem_req.req && !mem_rsp.ack |=> $stable(mem_req))
    else $error("memory request changed before ack");
  req_done_a: assert property (mem_req.req && mem_rsp.ack |=> !mem_req.req)
    else $error("memory request held after ack");
  busy_track_a: assert property (mem_req.req |-> busy)
    else $error("request without busy");
  unlock_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == NVAC_OFS_UNLOCK |-> avs_readdata == 32'h0) else $error("unlock read not 0");
  flash_range_a: assert property (mem_req.req && mem_req.space == NVAC_SP_FLASH |->
    mem_req.addr < NVAC_FLASH_LIMIT) else $error("access past implemented flash");
  launch_key_a: assert property ($rose(mem_req.req) && mem_req.op != NVAC_OP_READ |->
    $past(avs_write && !avs_waitrequest && avs_address == NVAC_OFS_CONTROL))
    else $error("write started without a control write");
  op_pick_a: assert property (launch |-> mem_req.op ==
    ($past(avs_writedata[NVAC_CTL_ERASE]) ? NVAC_OP_ERASE : NVAC_OP_WRITE))
    else $error("wrong operation kind");
  space_pick_a: assert property (launch |-> mem_req.space ==
    ($past(avs_writedata[NVAC_CTL_CONFIG_SPACE_SELECT]) ? NVAC_SP_CONFIG :
     $past(avs_writedata[NVAC_CTL_PGD]) ? NVAC_SP_FLASH : NVAC_SP_EEPROM))
    else $error("wrong memory space");
endmodule

bind nvac_top nvac_monitor nvac_monitor_i (.ref_clk, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_req, .mem_rsp, .busy);

// ### tb_nvac_top.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ns
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb_nvac_top
  import nvac_pkg::*;
;
  // ********
  // Signals
  // ********
  logic          ref_clk = 1'h0;
  logic          nrst = 1'h0;
  logic          power_on_nrst = 1'h0;
  logic [7:0]    avs_address = 8'h00;
  logic          avs_read = 1'h0;
  logic          avs_write = 1'h0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [3:0]    avs_byteenable = 4'hf;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  nvac_mem_req_s mem_req;
  nvac_mem_rsp_s mem_rsp = '0;
  logic          busy;
  logic [7:0]    mem_val = 8'h00;
  int            dly = 20;
  int            cnt = 0;
  int            num_errors = 0;
  int            check_count = 0;

  always #5 ref_clk = ~ref_clk;

  nvac_top nvac_top_i (.ref_clk, .nrst, .power_on_nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_req, .mem_rsp, .busy);

  // Far memory: acks after dly cycles; data is junk outside the ack cycle and the cycle after it
  always @(posedge ref_clk) begin
    cnt           <= (mem_req.req && !mem_rsp.ack) ? cnt + 1 : 0;
    mem_rsp.ack   <= mem_req.req && !mem_rsp.ack && cnt >= dly;
    mem_rsp.rdata <= (cnt >= dly) ? mem_val : ~mem_val;
  end

  // ********
  // Helpers
  // ********
  task automatic results();
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A spent wait limit counts as a mismatch and ends the run
  task automatic limit(input int n);
    if (n >= 100) begin
      num_errors++;
      $display("CHECK FAILED %0t wait limit", $time);
      results();
    end
  endtask

  // Request held until a rising edge samples waitrequest low; data taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 100);
    limit(n);
    q = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    `CHK(q, e, m)
  endtask

  // Permit, both keys back to back, then the trigger write
  task automatic launch(input logic [31:0] c);
    wr_reg(NVAC_OFS_CONTROL, 32'h04);
    wr_reg(NVAC_OFS_UNLOCK, {24'h0, NVAC_KEY_FIRST});
    wr_reg(NVAC_OFS_UNLOCK, {24'h0, NVAC_KEY_SECOND});
    wr_reg(NVAC_OFS_CONTROL, c);
  endtask

  // Wait for the memory request (v high) or for idle (v low)
  task automatic wait_req(input logic v);
    int n;
    n = 0;
    while ((v ? mem_req.req : !busy) !== 1'h1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    limit(n);
    @(posedge ref_clk);
  endtask

  // ********
  // Scenarios
  // ********
  // Reset values, an unmapped read and the storeless unlock port
  task automatic t_reset();
    logic [7:0] ofs [9] = '{NVAC_OFS_CONTROL, NVAC_OFS_UNLOCK, NVAC_OFS_ADDRESS,
                            NVAC_OFS_DATA, NVAC_OFS_FLAGS, NVAC_OFS_STATUS,
                            NVAC_OFS_TPTR, NVAC_OFS_TLATCH, 8'h20};
    foreach (ofs[i]) rd_chk(ofs[i], 32'h0, "reset value");
    wr_reg(NVAC_OFS_UNLOCK, 32'h55);
    rd_chk(NVAC_OFS_UNLOCK, 32'h0, "unlock stores");
  endtask

  // Trigger refused without stored permit, without keys and with broken keys
  task automatic t_refuse();
    wr_reg(NVAC_OFS_UNLOCK, 32'h55);
    wr_reg(NVAC_OFS_UNLOCK, 32'haa);
    wr_reg(NVAC_OFS_CONTROL, 32'h06);
    `CHK(busy, 1'h0, "no permit")
    rd_chk(NVAC_OFS_CONTROL, 32'h04, "no permit");
    wr_reg(NVAC_OFS_CONTROL, 32'h06);
    `CHK(busy, 1'h0, "no keys")
    wr_reg(NVAC_OFS_UNLOCK, 32'h55);
    wr_reg(NVAC_OFS_ADDRESS, 32'h0);
    wr_reg(NVAC_OFS_UNLOCK, 32'haa);
    wr_reg(NVAC_OFS_CONTROL, 32'h06);
    `CHK(busy, 1'h0, "broken keys")
    rd_chk(NVAC_OFS_CONTROL, 32'h04, "broken keys");
  endtask

  // Writes to every space and a flash erase, permit dropped while each one runs
  task automatic t_modes();
    logic [7:0]  ctl [5] = '{8'h06, 8'h86, 8'h46, 8'hc6, 8'h96};
    nvac_space_e sp [5] = '{NVAC_SP_EEPROM, NVAC_SP_FLASH, NVAC_SP_CONFIG, NVAC_SP_CONFIG,
                            NVAC_SP_FLASH};
    for (int i = 0; i < 5; i++) begin
      wr_reg(NVAC_OFS_ADDRESS, 32'h100 + i);
      wr_reg(NVAC_OFS_DATA, 32'h5a + i);
      launch({24'h0, ctl[i]});
      wait_req(1'h1);
      `CHK(mem_req.space, sp[i], "space")
      `CHK(mem_req.op, (i == 4) ? NVAC_OP_ERASE : NVAC_OP_WRITE, "op")
      `CHK(mem_req.addr, 21'h100 + i, "address")
      `CHK(mem_req.wdata, 8'h5a + i, "write data")
      wr_reg(NVAC_OFS_CONTROL, 32'h0);
      `CHK(mem_req.req, 1'h1, "permit drop")
      wait_req(1'h0);
      rd_chk(NVAC_OFS_CONTROL, {24'h0, ctl[i] & 8'hd0}, "trigger clear");
      rd_chk(NVAC_OFS_FLAGS, 32'h1, "done flag");
      rd_chk(NVAC_OFS_FLAGS, 32'h1, "flag holds");
      wr_reg(NVAC_OFS_FLAGS, 32'h1);
      rd_chk(NVAC_OFS_FLAGS, 32'h0, "flag clear");
    end
  endtask

  // Data read, then a read trigger refused with program space selected
  task automatic t_read();
    mem_val = 8'ha5;
    wr_reg(NVAC_OFS_ADDRESS, 32'h33);
    wr_reg(NVAC_OFS_CONTROL, 32'h01);
    wait_req(1'h1);
    `CHK(mem_req.op, NVAC_OP_READ, "read op")
    `CHK(mem_req.space, NVAC_SP_EEPROM, "read space")
    wait_req(1'h0);
    rd_chk(NVAC_OFS_DATA, 32'ha5, "read data");
    rd_chk(NVAC_OFS_CONTROL, 32'h0, "read clear");
    wr_reg(NVAC_OFS_CONTROL, 32'h41);
    wait_req(1'h1);
    `CHK(mem_req.space, NVAC_SP_CONFIG, "config read")
    wait_req(1'h0);
    rd_chk(NVAC_OFS_CONTROL, 32'h40, "config read clear");
    wr_reg(NVAC_OFS_CONTROL, 32'h81);
    `CHK(busy, 1'h0, "flash read")
    rd_chk(NVAC_OFS_CONTROL, 32'h80, "flash read");
  endtask

  // Table fetch at the last flash byte and at the first byte past it
  task automatic t_limit();
    mem_val = 8'h77;
    wr_reg(NVAC_OFS_TPTR, 32'h1fff);
    wait_req(1'h1);
    `CHK(mem_req.addr, 21'h1fff, "fetch address")
    wait_req(1'h0);
    rd_chk(NVAC_OFS_TLATCH, 32'h77, "fetch data");
    rd_chk(NVAC_OFS_TPTR, 32'h1fff, "pointer");
    wr_reg(NVAC_OFS_TPTR, 32'h2000);
    `CHK(busy, 1'h0, "no fetch past flash")
    rd_chk(NVAC_OFS_TLATCH, 32'h0, "past flash");
    wr_reg(NVAC_OFS_ADDRESS, 32'h2000);
    launch(32'h86);
    `CHK(mem_req.req, 1'h0, "no request past flash")
    rd_chk(NVAC_OFS_FLAGS, 32'h1, "write past flash");
    wr_reg(NVAC_OFS_FLAGS, 32'h1);
  endtask

  // Device reset in mid-write; memory never answers meanwhile
  task automatic t_abort();
    dly = 1000;
    wr_reg(NVAC_OFS_ADDRESS, 32'h44);
    wr_reg(NVAC_OFS_DATA, 32'h99);
    launch(32'h06);
    wait_req(1'h1);
    nrst <= 1'h0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    dly = 20;
    repeat (3) @(posedge ref_clk);
    rd_chk(NVAC_OFS_CONTROL, 32'h08, "abort flag");
    rd_chk(NVAC_OFS_ADDRESS, 32'h0, "address cleared");
    rd_chk(NVAC_OFS_DATA, 32'h0, "data cleared");
    wr_reg(NVAC_OFS_CONTROL, 32'h0);
    rd_chk(NVAC_OFS_CONTROL, 32'h0, "abort clear");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst          <= 1'h1;
    power_on_nrst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_refuse();
    t_modes();
    t_read();
    t_limit();
    t_abort();
    results();
  end
endmodule
